/* File: jrxcfg_pkg.sv */
package jrxcfg_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned RATE_W = 12;
  localparam int unsigned LRATE_W = 19;
  localparam int unsigned ORATE_W = 15;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_LANE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LRATE = 8'h10;
  localparam logic [7:0] OFS_ORATE = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_INTERP_LSB = 4;
  localparam int unsigned CTRL_DUAL_BIT = 12;
  localparam int unsigned CTRL_SCR_BIT = 13;
  localparam int unsigned CTRL_SUBCL_BIT = 14;
  localparam int unsigned CTRL_K32_BIT = 15;
  localparam int unsigned CTRL_SUM_BIT = 16;
  localparam int unsigned CTRL_GO_BIT = 17;
  localparam int unsigned CTRL_RST_LSB = 18;
  localparam int unsigned LANE_USED_LSB = 0;
  localparam int unsigned LANE_DID_LSB = 8;
  localparam int unsigned LANE_BID_LSB = 16;
  localparam int unsigned STAT_OK_BIT = 0;
  localparam int unsigned STAT_ERR_LSB = 1;
  localparam int unsigned STAT_RUN_BIT = 6;
  localparam int unsigned STAT_FROZEN_BIT = 7;
  localparam int unsigned STAT_REFUSED_BIT = 8;
  localparam int unsigned STAT_SUM_LSB = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_8000;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam logic [31:0] LANE_RST = 32'h0000_0000;

  // ****************************************
  // Codes and limits
  // ****************************************
  localparam logic [7:0] INTERP_1X = 8'h00;
  localparam logic [7:0] INTERP_2X = 8'h01;
  localparam logic [7:0] INTERP_4X = 8'h03;
  localparam logic [7:0] INTERP_8X = 8'h04;
  localparam logic [RATE_W-1:0] RATE_MAX_WIDE = 12'h424;
  localparam logic [RATE_W-1:0] RATE_MAX_4X = 12'h2bc;
  localparam logic [RATE_W-1:0] RATE_MAX_8X = 12'h15e;
  localparam logic [LRATE_W-1:0] LANE_MIN_MBPS = 19'h005a0;
  localparam logic [LRATE_W-1:0] LANE_MAX_MBPS = 19'h03070;
  localparam logic [LRATE_W+1:0] LANE_RATE_MULT = 21'h000014;
  localparam logic [4:0] RES_M1 = 5'h0f;
  localparam logic [4:0] K_LONG_M1 = 5'h1f;
  localparam logic [4:0] K_SHORT_M1 = 5'h0f;
  localparam logic [2:0] JESD_VER = 3'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic legal;
    logic single_only;
    logic k16_ok;
    logic [2:0] m;
    logic [3:0] l;
    logic [1:0] s;
    logic [2:0] f;
  } jrxcfg_mode_type;

  typedef struct packed {
    logic bad_mode;
    logic bad_interp;
    logic rate_high;
    logic lane_range;
    logic lane_mismatch;
  } jrxcfg_err_type;

  typedef struct packed {
    logic [3:0] mode;
    logic [7:0] interp_factor_sel;
    logic two_link_select;
    logic scramble;
    logic subclass;
    logic cfg_sum_method;
    logic [4:0] l_m1;
    logic [7:0] f_m1;
    logic [4:0] k_m1;
    logic [7:0] m_m1;
    logic [4:0] n_m1;
    logic [4:0] np_m1;
    logic [4:0] s_m1;
    logic hd;
    logic [7:0] did;
    logic [3:0] bid;
    logic [7:0] lanes;
    logic [7:0] lane_power_off_mask;
    logic [7:0] first_lane_cfg_sum;
  } jrxcfg_link_cfg_type;

  function automatic logic [3:0] jrxcfg_popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : jrxcfg_popcount

endpackage : jrxcfg_pkg

/* File: jrxcfg_calc.sv */
module jrxcfg_calc (
  input logic [31:0] ctrl,
  input logic [31:0] lane_word,
  input logic [jrxcfg_pkg::RATE_W-1:0] input_sample_rate,
  output jrxcfg_pkg::jrxcfg_link_cfg_type cfg,
  output jrxcfg_pkg::jrxcfg_err_type err,
  output logic [jrxcfg_pkg::LRATE_W-1:0] serial_bit_rate,
  output logic [jrxcfg_pkg::ORATE_W-1:0] converter_output_rate
);

  // ****************************************
  // Mode table
  // ****************************************
  function automatic jrxcfg_pkg::jrxcfg_mode_type mode_params(input logic [3:0] md);
    jrxcfg_pkg::jrxcfg_mode_type p;
    p = '0;
    case (md)
      4'h0: p = '{1'b1, 1'b1, 1'b0, 3'h4, 4'h8, 2'h1, 3'h1};
      4'h1: p = '{1'b1, 1'b1, 1'b1, 3'h4, 4'h8, 2'h2, 3'h2};
      4'h2: p = '{1'b1, 1'b1, 1'b1, 3'h4, 4'h4, 2'h1, 3'h2};
      4'h3: p = '{1'b1, 1'b1, 1'b1, 3'h4, 4'h2, 2'h1, 3'h4};
      4'h4: p = '{1'b1, 1'b0, 1'b0, 3'h2, 4'h4, 2'h1, 3'h1};
      4'h5: p = '{1'b1, 1'b0, 1'b1, 3'h2, 4'h4, 2'h2, 3'h2};
      4'h6: p = '{1'b1, 1'b0, 1'b1, 3'h2, 4'h2, 2'h1, 3'h2};
      4'h7: p = '{1'b1, 1'b0, 1'b1, 3'h2, 4'h1, 2'h1, 3'h4};
      4'h9: p = '{1'b1, 1'b0, 1'b0, 3'h1, 4'h2, 2'h1, 3'h1};
      4'ha: p = '{1'b1, 1'b0, 1'b1, 3'h1, 4'h1, 2'h1, 3'h2};
      default: p = '0;
    endcase
    return p;
  endfunction : mode_params

  logic [3:0] mode;
  logic [7:0] interp;
  logic dual;
  logic k32;
  logic [7:0] used;
  logic [20:0] prod;
  jrxcfg_pkg::jrxcfg_mode_type mp;
  logic [jrxcfg_pkg::RATE_W-1:0] limit;
  logic [7:0] fsum;
  logic [7:0] rsum;
  logic [7:0] pk [11];

  assign mode = ctrl[jrxcfg_pkg::CTRL_MODE_LSB +: 4];
  assign interp = ctrl[jrxcfg_pkg::CTRL_INTERP_LSB +: 8];
  assign dual = ctrl[jrxcfg_pkg::CTRL_DUAL_BIT];
  assign k32 = ctrl[jrxcfg_pkg::CTRL_K32_BIT];
  assign used = lane_word[jrxcfg_pkg::LANE_USED_LSB +: 8];

  always_comb begin
    mp = mode_params(mode);
    err.bad_mode = !mp.legal || (dual && mp.single_only) || (!k32 && !mp.k16_ok);
    err.bad_interp = !(interp == jrxcfg_pkg::INTERP_1X || interp == jrxcfg_pkg::INTERP_2X ||
                       interp == jrxcfg_pkg::INTERP_4X || interp == jrxcfg_pkg::INTERP_8X);
    case (interp)
      jrxcfg_pkg::INTERP_4X: limit = jrxcfg_pkg::RATE_MAX_4X;
      jrxcfg_pkg::INTERP_8X: limit = jrxcfg_pkg::RATE_MAX_8X;
      default: limit = jrxcfg_pkg::RATE_MAX_WIDE;
    endcase
    err.rate_high = (input_sample_rate > limit) || (input_sample_rate == '0);
    case (interp)
      jrxcfg_pkg::INTERP_2X: converter_output_rate = 15'(input_sample_rate) << 1;
      jrxcfg_pkg::INTERP_4X: converter_output_rate = 15'(input_sample_rate) << 2;
      jrxcfg_pkg::INTERP_8X: converter_output_rate = 15'(input_sample_rate) << 3;
      default: converter_output_rate = 15'(input_sample_rate);
    endcase
    prod = 21'(input_sample_rate) * jrxcfg_pkg::LANE_RATE_MULT * 21'(mp.m);
    case (mp.l)
      4'h2: serial_bit_rate = 19'(prod >> 1);
      4'h4: serial_bit_rate = 19'(prod >> 2);
      4'h8: serial_bit_rate = 19'(prod >> 3);
      default: serial_bit_rate = 19'(prod);
    endcase
    err.lane_range = (serial_bit_rate < jrxcfg_pkg::LANE_MIN_MBPS) ||
                     (serial_bit_rate > jrxcfg_pkg::LANE_MAX_MBPS);
    // used lanes match the lane count, or twice it with two links
    err.lane_mismatch = jrxcfg_pkg::jrxcfg_popcount(used) != (dual ? {mp.l[2:0], 1'b0} : mp.l);
    cfg.mode = mode;
    cfg.interp_factor_sel = interp;
    cfg.two_link_select = dual;
    cfg.scramble = ctrl[jrxcfg_pkg::CTRL_SCR_BIT];
    cfg.subclass = ctrl[jrxcfg_pkg::CTRL_SUBCL_BIT];
    cfg.cfg_sum_method = ctrl[jrxcfg_pkg::CTRL_SUM_BIT];
    cfg.l_m1 = 5'(mp.l) - 5'h01;
    cfg.f_m1 = 8'(mp.f) - 8'h01;
    cfg.k_m1 = k32 ? jrxcfg_pkg::K_LONG_M1 : jrxcfg_pkg::K_SHORT_M1;
    cfg.m_m1 = 8'(mp.m) - 8'h01;
    cfg.n_m1 = jrxcfg_pkg::RES_M1;
    cfg.np_m1 = jrxcfg_pkg::RES_M1;
    cfg.s_m1 = 5'(mp.s) - 5'h01;
    cfg.hd = (mp.f == 3'h1);
    cfg.did = lane_word[jrxcfg_pkg::LANE_DID_LSB +: 8];
    cfg.bid = lane_word[jrxcfg_pkg::LANE_BID_LSB +: 4];
    cfg.lanes = 8'((9'h001 << mp.l) - 9'h001);
    cfg.lane_power_off_mask = ~used;
    fsum = cfg.did + 8'(cfg.bid) + 8'(cfg.scramble) + 8'(cfg.l_m1) + cfg.f_m1 +
           8'(cfg.k_m1) + cfg.m_m1 + 8'(cfg.n_m1) + 8'(cfg.subclass) + 8'(cfg.np_m1) +
           8'(jrxcfg_pkg::JESD_VER) + 8'(cfg.s_m1) + 8'(cfg.hd);
    pk[0] = cfg.did;
    pk[1] = {4'h0, cfg.bid};
    pk[2] = 8'h00;
    pk[3] = {cfg.scramble, 2'h0, cfg.l_m1};
    pk[4] = cfg.f_m1;
    pk[5] = {3'h0, cfg.k_m1};
    pk[6] = cfg.m_m1;
    pk[7] = {3'h0, cfg.n_m1};
    pk[8] = {2'h0, cfg.subclass, cfg.np_m1};
    pk[9] = {jrxcfg_pkg::JESD_VER, cfg.s_m1};
    pk[10] = {cfg.hd, 7'h00};
    rsum = 8'h00;
    for (int i = 0; i < 11; i++) begin
      rsum = rsum + pk[i];
    end
    cfg.first_lane_cfg_sum = cfg.cfg_sum_method ? rsum : fsum;
  end

endmodule : jrxcfg_calc

/* File: jrxcfg_ctrl.sv */
// Summary of operation
// - Input rate capped per interpolation factor
// - Modes 0-3 single link, four converters
// - Modes 4-7, 9, 10 single or dual
// - Lane rate 20*rate*M/L within range
// - Density flag set only for one octet
// - Resolution and sample bits both sixteen
// - Modes 0, 4, 9 need K 32
// - Both links share identical parameters
// - Transmitter matches receiver link parameters
// - Interpolation fixed before link comes up
module jrxcfg_ctrl (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output jrxcfg_pkg::jrxcfg_link_cfg_type link_cfg,
  output logic cfg_load,
  output logic [1:0] link_enable,
  output logic [1:0] link_reset_n
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_RUN
  } jrxcfg_state_type;

  jrxcfg_state_type st_q;
  jrxcfg_state_type st_d;
  logic [31:0] ctrl_q;
  logic [31:0] rate_q;
  logic [31:0] lane_q;
  logic [31:0] hrdata_q;
  logic wr_q;
  logic [7:0] waddr_q;
  logic frozen_q;
  logic refused_q;
  jrxcfg_pkg::jrxcfg_link_cfg_type cfg_q;
  logic [1:0] en_q;
  logic [1:0] rstn_q;
  jrxcfg_pkg::jrxcfg_link_cfg_type cfg_c;
  jrxcfg_pkg::jrxcfg_err_type err_c;
  logic [jrxcfg_pkg::LRATE_W-1:0] lrate_c;
  logic [jrxcfg_pkg::ORATE_W-1:0] orate_c;
  logic cfg_ok;
  logic go;
  logic accept;
  logic wr_ctrl;
  logic wr_stat;
  logic [31:0] stat_word;

  // ****************************************
  // Configuration derivation
  // ****************************************
  jrxcfg_calc u_calc (
    .ctrl(ctrl_q),
    .lane_word(lane_q),
    .input_sample_rate(rate_q[jrxcfg_pkg::RATE_W-1:0]),
    .cfg(cfg_c),
    .err(err_c),
    .serial_bit_rate(lrate_c),
    .converter_output_rate(orate_c)
  );

  assign cfg_ok = (err_c == '0);
  assign go = ctrl_q[jrxcfg_pkg::CTRL_GO_BIT];

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign accept = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr_ctrl = wr_q && (waddr_q == jrxcfg_pkg::OFS_CTRL);
  assign wr_stat = wr_q && (waddr_q == jrxcfg_pkg::OFS_STATUS);

  always_comb begin
    stat_word = '0;
    stat_word[jrxcfg_pkg::STAT_OK_BIT] = cfg_ok;
    stat_word[jrxcfg_pkg::STAT_ERR_LSB +: 5] = err_c;
    stat_word[jrxcfg_pkg::STAT_RUN_BIT] = (st_q == ST_RUN);
    stat_word[jrxcfg_pkg::STAT_FROZEN_BIT] = frozen_q;
    stat_word[jrxcfg_pkg::STAT_REFUSED_BIT] = refused_q;
    stat_word[jrxcfg_pkg::STAT_SUM_LSB +: 8] = cfg_c.first_lane_cfg_sum;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_q <= accept && hwrite && (hsize == 3'h2);
      waddr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      case (haddr[7:0])
        jrxcfg_pkg::OFS_CTRL: hrdata_q <= ctrl_q;
        jrxcfg_pkg::OFS_RATE: hrdata_q <= rate_q;
        jrxcfg_pkg::OFS_LANE: hrdata_q <= lane_q;
        jrxcfg_pkg::OFS_STATUS: hrdata_q <= stat_word;
        jrxcfg_pkg::OFS_LRATE: hrdata_q <= 32'(lrate_c);
        jrxcfg_pkg::OFS_ORATE: hrdata_q <= 32'(orate_c);
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= jrxcfg_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {12'h000, hwdata[19:0]};
      if (st_q != ST_IDLE) begin
        ctrl_q[jrxcfg_pkg::CTRL_INTERP_LSB +: 8] <= ctrl_q[jrxcfg_pkg::CTRL_INTERP_LSB +: 8];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_q <= jrxcfg_pkg::RATE_RST;
      lane_q <= jrxcfg_pkg::LANE_RST;
    end else if (wr_q) begin
      if (waddr_q == jrxcfg_pkg::OFS_RATE) begin
        rate_q <= 32'(hwdata[jrxcfg_pkg::RATE_W-1:0]);
      end
      if (waddr_q == jrxcfg_pkg::OFS_LANE) begin
        lane_q <= {12'h000, hwdata[19:0]};
      end
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frozen_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (wr_ctrl && (st_q != ST_IDLE) &&
          (hwdata[jrxcfg_pkg::CTRL_INTERP_LSB +: 8] != ctrl_q[jrxcfg_pkg::CTRL_INTERP_LSB +: 8])) begin
        frozen_q <= 1'b1;
      end else if (wr_stat && hwdata[jrxcfg_pkg::STAT_FROZEN_BIT]) begin
        frozen_q <= 1'b0;
      end
      if ((st_q == ST_IDLE) && go && !cfg_ok) begin
        refused_q <= 1'b1;
      end else if (wr_stat && hwdata[jrxcfg_pkg::STAT_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Link bring-up sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      // start only with an error-free configuration
      ST_IDLE: begin
        if (go && cfg_ok) begin
          st_d = ST_LOAD;
        end
      end
      ST_LOAD: st_d = ST_RUN;
      ST_RUN: begin
        if (!go) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= '0;
    end else if ((st_q == ST_IDLE) && (st_d == ST_LOAD)) begin
      cfg_q <= cfg_c;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 2'b00;
      rstn_q <= 2'b00;
    end else if (st_d == ST_RUN) begin
      en_q <= cfg_q.two_link_select ? 2'b11 : 2'b01;
      rstn_q[0] <= !ctrl_q[jrxcfg_pkg::CTRL_RST_LSB];
      rstn_q[1] <= cfg_q.two_link_select && !ctrl_q[jrxcfg_pkg::CTRL_RST_LSB + 1];
    end else begin
      en_q <= 2'b00;
      rstn_q <= 2'b00;
    end
  end

  assign link_cfg = cfg_q;
  assign cfg_load = (st_q == ST_LOAD);
  assign link_enable = en_q;
  assign link_reset_n = rstn_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_start;
    (st_q == ST_IDLE) && go && cfg_ok;
  endsequence

  sequence s_bringup;
    cfg_load ##1 (link_enable != 2'b00) && !cfg_load;
  endsequence

  property p_bringup;
    @(posedge hclk) disable iff (!hresetn) s_start |=> s_bringup;
  endproperty
  a_bringup: assert property (p_bringup) else $error("link did not come up after start");

  property p_refuse;
    @(posedge hclk) disable iff (!hresetn)
      ((st_q == ST_IDLE) && go && !cfg_ok) |=> !cfg_load && (link_enable == 2'b00) ##1 refused_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad configuration was not refused");

  property p_density;
    @(posedge hclk) disable iff (!hresetn)
      cfg_load |-> (link_cfg.hd == (link_cfg.f_m1 == 8'h00));
  endproperty
  a_density: assert property (p_density) else $error("density flag wrong");

  property p_resolution;
    @(posedge hclk) disable iff (!hresetn)
      cfg_load |-> (link_cfg.n_m1 == 5'h0f) && (link_cfg.np_m1 == 5'h0f);
  endproperty
  a_resolution: assert property (p_resolution) else $error("resolution not sixteen");

  property p_kframes;
    @(posedge hclk) disable iff (!hresetn)
      (cfg_load && (link_cfg.mode == 4'h0 || link_cfg.mode == 4'h4 || link_cfg.mode == 4'h9))
      |-> (link_cfg.k_m1 == 5'h1f);
  endproperty
  a_kframes: assert property (p_kframes) else $error("K not 32 for this mode");

  property p_lanes;
    @(posedge hclk) disable iff (!hresetn)
      cfg_load |-> (link_cfg.lanes == 8'((9'h001 << (link_cfg.l_m1 + 5'h01)) - 9'h001));
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane mask not thermometer");

  property p_power;
    @(posedge hclk) disable iff (!hresetn)
      cfg_load |-> (jrxcfg_pkg::jrxcfg_popcount(~link_cfg.lane_power_off_mask) ==
                    4'((link_cfg.l_m1 + 5'h01) << link_cfg.two_link_select));
  endproperty
  a_power: assert property (p_power) else $error("powered lanes do not match count");

  property p_interp_hold;
    @(posedge hclk) disable iff (!hresetn)
      (st_q == ST_RUN) && $past(st_q == ST_RUN) |->
        $stable(ctrl_q[jrxcfg_pkg::CTRL_INTERP_LSB +: 8]);
  endproperty
  a_interp_hold: assert property (p_interp_hold) else $error("interpolation changed in run");

  property p_dual;
    @(posedge hclk) disable iff (!hresetn)
      (st_q == ST_RUN) && (st_d == ST_RUN) |=>
        (link_enable == (link_cfg.two_link_select ? 2'b11 : 2'b01)) &&
        (link_cfg.two_link_select || !link_reset_n[1]);
  endproperty
  a_dual: assert property (p_dual) else $error("link enables do not follow link count");

endmodule : jrxcfg_ctrl

/* File: jrxcfg_dev_model.sv */
// ****************************************
// Receiving device model
// ****************************************
module jrxcfg_dev_model (
  input logic hclk,
  input logic hresetn,
  input jrxcfg_pkg::jrxcfg_link_cfg_type link_cfg,
  input logic cfg_load,
  input logic [1:0] link_enable,
  input logic [1:0] link_reset_n,
  output logic [1:0] link_up,
  output logic descramble,
  output logic det_latency,
  output logic fmt_ok,
  output logic [7:0] rx_power_on
);
  timeunit 1ns;
  timeprecision 1ps;
  jrxcfg_pkg::jrxcfg_link_cfg_type cfg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= '0;
    end else if (cfg_load) begin
      cfg_q <= link_cfg;
    end
  end

  assign link_up = link_enable & link_reset_n & {cfg_q.two_link_select, 1'b1};
  assign descramble = cfg_q.scramble;
  assign det_latency = cfg_q.subclass;
  assign fmt_ok = (cfg_q.n_m1 == 5'h0f) && (cfg_q.np_m1 == 5'h0f)
      && (cfg_q.hd == (cfg_q.f_m1 == 8'h00));
  assign rx_power_on = ~cfg_q.lane_power_off_mask;
endmodule : jrxcfg_dev_model

/* File: jrxcfg_ctrl_tb.sv */
module jrxcfg_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MD[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10};
  localparam int MM[10] = '{4, 4, 4, 4, 2, 2, 2, 2, 1, 1};
  localparam int LL[10] = '{8, 8, 4, 2, 4, 4, 2, 1, 2, 1};
  localparam int SS[10] = '{1, 2, 1, 1, 1, 2, 1, 1, 1, 1};
  localparam int FF[10] = '{1, 2, 2, 4, 1, 2, 2, 4, 1, 2};
  localparam int IC[4] = '{0, 1, 3, 4};
  localparam int CAP[4] = '{1060, 1060, 700, 350};
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  jrxcfg_pkg::jrxcfg_link_cfg_type link_cfg;
  logic cfg_load;
  logic [1:0] link_enable;
  logic [1:0] link_reset_n;
  logic [1:0] link_up;
  logic descramble;
  logic det_latency;
  logic fmt_ok;
  logic [7:0] rx_power_on;
  int n_mismatch;
  int n_checks;

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  jrxcfg_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link_cfg(link_cfg), .cfg_load(cfg_load),
    .link_enable(link_enable), .link_reset_n(link_reset_n));

  jrxcfg_dev_model dev (.hclk(hclk), .hresetn(hresetn), .link_cfg(link_cfg), .cfg_load(cfg_load),
    .link_enable(link_enable), .link_reset_n(link_reset_n), .link_up(link_up),
    .descramble(descramble), .det_latency(det_latency), .fmt_ok(fmt_ok),
    .rx_power_on(rx_power_on));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  function automatic logic [7:0] cks(input int sm, did, bid, sc, l, f, k, m, sb, s, hd);
    if (sm == 1) return 8'(did + bid + sc * 128 + l + f + k + m + 15 + sb * 32 + 15 + 32 + s + hd * 128);
    return 8'(did + bid + sc + l + f + k + m + 15 + sb + 15 + 1 + s + hd);
  endfunction : cks

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic run_mode(input int i, input int d);
    int j, m, l, f, s, r, k, u, t, sc, sb, sm, did, bid;
    logic [7:0] sum;
    logic [31:0] c;
    logic [31:0] v;
    logic [31:0] e;
    j = $urandom_range(3);
    m = MM[i];
    l = LL[i];
    f = FF[i];
    s = SS[i];
    r = 12400 * l / (20 * m);
    if (r > CAP[j]) r = CAP[j];
    r = $urandom_range(r, (1440 * l + 20 * m - 1) / (20 * m));
    k = (MD[i] == 0 || MD[i] == 4 || MD[i] == 9) ? 1 : $urandom_range(1);
    sc = $urandom_range(1);
    sb = $urandom_range(1);
    sm = $urandom_range(1);
    did = $urandom_range(255);
    bid = $urandom_range(15);
    t = (1 << (l * (d + 1))) - 1;
    u = $urandom_range(7);
    u = ((t << u) | (t >> (8 - u))) & 255;
    sum = cks(sm, did, bid, sc, l - 1, f - 1, k ? 31 : 15, m - 1, sb, s - 1, f == 1);
    c = MD[i] | (IC[j] << 4) | (d << 12) | (sc << 13) | (sb << 14) | (k << 15) | (sm << 16);
    wr(jrxcfg_pkg::OFS_RATE, 32'(r));
    wr(jrxcfg_pkg::OFS_LANE, 32'(u | (did << 8) | (bid << 16)));
    wr(jrxcfg_pkg::OFS_CTRL, c);
    rd(jrxcfg_pkg::OFS_STATUS, v);
    chk("status", {v[23:16], v[6:0]}, {sum, 7'h01});
    rd(jrxcfg_pkg::OFS_LRATE, v);
    chk("lane rate", v, 32'(20 * r * m / l));
    rd(jrxcfg_pkg::OFS_ORATE, v);
    chk("output rate", v, 32'(r << j));
    wr(jrxcfg_pkg::OFS_CTRL, c | 32'h20000);
    for (int n = 0; n < 20 && cfg_load !== 1'b1; n++) @(posedge hclk);
    chk("load", cfg_load, 1'b1);
    v = {link_cfg.l_m1, link_cfg.f_m1, link_cfg.k_m1, link_cfg.m_m1, link_cfg.s_m1, link_cfg.hd};
    e = {5'(l - 1), 8'(f - 1), 5'(k ? 31 : 15), 8'(m - 1), 5'(s - 1), 1'(f == 1)};
    chk("shape", v, e);
    e = 32'((((1 << l) - 1) << 8) | (255 - u));
    chk("lanes", {link_cfg.lanes, link_cfg.lane_power_off_mask}, e);
    chk("sum", {link_cfg.first_lane_cfg_sum, link_cfg.interp_factor_sel}, {sum, 8'(IC[j])});
    @(posedge hclk);
    chk("enables", {link_enable, link_reset_n}, {2'(d * 2 + 1), 2'(d * 2 + 1)});
    e = {2'(d * 2 + 1), 1'(sc), 1'(sb), 1'b1, 8'(u)};
    chk("device", {link_up, descramble, det_latency, fmt_ok, rx_power_on}, e);
    c = (c & 32'hfffff00f) | (IC[(j + 1) % 4] << 4) | 32'h60000;
    wr(jrxcfg_pkg::OFS_CTRL, c);
    rd(jrxcfg_pkg::OFS_CTRL, v);
    chk("interp kept", v[11:4], IC[j]);
    chk("link reset", {link_reset_n, link_up}, {2'(d * 2), 2'(d * 2)});
    rd(jrxcfg_pkg::OFS_STATUS, v);
    chk("flags", v[8:6], 3'h3);
    wr(jrxcfg_pkg::OFS_CTRL, 32'h8000);
    wr(jrxcfg_pkg::OFS_STATUS, 32'h180);
    rd(jrxcfg_pkg::OFS_STATUS, v);
    chk("stopped", {v[8:6], link_enable}, 5'h0);
    $display("done mode %0d links %0d", MD[i], d + 1);
  endtask : run_mode

  task automatic err_case(input logic [31:0] c, input int r, input logic [7:0] u, input int b);
    logic [31:0] v;
    wr(jrxcfg_pkg::OFS_RATE, 32'(r));
    wr(jrxcfg_pkg::OFS_LANE, {24'h0, u});
    wr(jrxcfg_pkg::OFS_CTRL, c | (b >= 0 ? 32'h20000 : 32'h0));
    rd(jrxcfg_pkg::OFS_STATUS, v);
    chk("cfg ok", v[0], b < 0);
    if (b > 0) chk("error bit", v[b], 1'b1);
    if (b >= 0) chk("refused", {v[8], link_enable, cfg_load}, 4'h8);
    wr(jrxcfg_pkg::OFS_CTRL, 32'h8000);
    wr(jrxcfg_pkg::OFS_STATUS, 32'h100);
    $display("done case %h rate %0d", c, r);
  endtask : err_case

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    #1ms;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'he099));
    repeat (8) @(posedge hclk);
    chk("reset out", {cfg_load, link_enable, link_reset_n, hreadyout, hresp, link_cfg == '0}, 8'h05);
    hresetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(8'(a == 3 ? 24 : a * 4), v);
      chk("reset value", v, a == 0 ? jrxcfg_pkg::CTRL_RST : 32'h0);
    end
    wr(jrxcfg_pkg::OFS_LRATE, 32'hffffffff);
    rd(jrxcfg_pkg::OFS_LRATE, v);
    chk("read only", v, 32'h0);
    $display("done reset");
    for (int i = 0; i < 10; i++) begin
      for (int d = 0; d < 2; d++) begin
        if (d == 0 || i >= 4) run_mode(i, d);
      end
    end
    err_case(32'h8008, 100, 8'hff, 5);
    err_case(32'h800b, 100, 8'hff, 5);
    err_case(32'h0000, 200, 8'hff, 0);
    err_case(32'h9000, 200, 8'hff, 0);
    err_case(32'h8020, 200, 8'hff, 4);
    err_case(32'h8030, 701, 8'hff, 3);
    err_case(32'h8030, 700, 8'hff, -1);
    err_case(32'h8040, 351, 8'hff, 3);
    err_case(32'h8040, 350, 8'hff, -1);
    err_case(32'h8010, 1061, 8'hff, 3);
    err_case(32'h8000, 1060, 8'hff, -1);
    err_case(32'h8000, 0, 8'hff, 3);
    err_case(32'h8000, 143, 8'hff, 2);
    err_case(32'h8000, 144, 8'hff, -1);
    err_case(32'h8007, 311, 8'h01, 2);
    err_case(32'h8000, 200, 8'h7f, 1);
    results();
  end
endmodule : jrxcfg_ctrl_tb
